// ---- design/csm_defs.svh ----
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH
`define CSM_OFF_CTRL    8'h00
`define CSM_OFF_STATUS  8'h04
`define CSM_OFF_GR0     8'h08
`define CSM_OFF_PC      8'h20
`define CSM_NUM_GR      6
`define CSM_CTRL_INL    3
`define CSM_CTRL_START  8
`define CSM_ST_BUSY     0
`define CSM_ST_DONE     1
`define CSM_ST_C        4
`define CSM_ST_V        5
`define CSM_ST_Z        6
`define CSM_ST_N        7
`define CSM_WORD_STEP   16'h0002
`define CSM_ONE         16'h0001
`define CSM_FILL_LAST   2'h2
`define CSM_TBL_LAST    2'h3
`endif

// ---- design/csm_pkg.sv ----
package csm_pkg;
	typedef enum logic [1:0] {
		CSM_OP_LEFT  = 2'b00,
		CSM_OP_RIGHT = 2'b01,
		CSM_OP_TRANS = 2'b10
	} csm_op_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_OPF  = 4'b0001,
		ST_DSC  = 4'b0010,
		ST_CALC = 4'b0011,
		ST_CPY  = 4'b0100,
		ST_SRD  = 4'b0101,
		ST_TRD  = 4'b0110,
		ST_DWR  = 4'b0111,
		ST_FIL  = 4'b1000,
		ST_FWR  = 4'b1001,
		ST_FIN  = 4'b1010
	} csm_state_e;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic        word;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} csm_mem_req_s;
endpackage : csm_pkg

// ---- design/csm_unit.sv ----
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "csm_defs.svh"
module csm_unit
	import csm_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// memory port
	output csm_mem_req_s      mem_req,
	input  wire logic         mem_ack,
	input  wire logic [15:0]  mem_rdata,
	// status
	output logic              busy,
	output logic              done
);

	csm_state_e   state_reg;
	csm_op_e      op_reg;
	logic         inl_reg;
	logic [15:0]  gr_reg [0:`CSM_NUM_GR-1];
	logic [15:0]  pc_reg;
	logic [15:0]  s_len_reg;
	logic [15:0]  s_addr_reg;
	logic [15:0]  d_len_reg;
	logic [15:0]  d_addr_reg;
	logic [7:0]   fill_reg;
	logic [15:0]  tbl_reg;
	logic [15:0]  ptr_s_reg;
	logic [15:0]  ptr_d_reg;
	logic [1:0]   idx_reg;
	logic [15:0]  n_reg;
	logic [15:0]  so_reg;
	logic [15:0]  do_reg;
	logic         desc_reg;
	logic [15:0]  cnt_reg;
	logic [7:0]   byte_reg;
	logic [3:0]   flags_reg;
	logic         done_reg;
	logic         busy_reg;
	csm_mem_req_s mreq_reg;

	logic         wr_acc;
	logic         rd_setup;
	logic         hit;
	logic         start;
	logic         ack;
	logic [15:0]  k;
	logic [15:0]  src_a;
	logic [15:0]  dst_a;
	logic [15:0]  fill_a;
	logic [15:0]  n_calc;
	logic [15:0]  fill_cnt;

	function automatic logic [15:0] min16(input logic [15:0] a,
		input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction : min16

	// n, z, v, c of src.len - dst.len
	function automatic logic [3:0] cmp_flags(input logic [15:0] s,
		input logic [15:0] d);
		logic [16:0] diff;
		logic        fn;
		logic        fz;
		logic        fv;
		logic        fc;
		diff = {1'b0, s} + {1'b0, ~d} + 17'h00001;
		fn = diff[15];
		fz = (diff[15:0] == 16'h0000);
		fv = (s[15] != d[15]) && (d[15] == diff[15]);
		fc = ~diff[16];
		cmp_flags = {fn, fz, fv, fc};
	endfunction : cmp_flags

	function automatic csm_mem_req_s rd_word(input logic [15:0] a);
		rd_word = '{valid: 1'b1, we: 1'b0, word: 1'b1, addr: a,
			wdata: 8'h00};
	endfunction : rd_word

	function automatic csm_mem_req_s rd_byte(input logic [15:0] a);
		rd_byte = '{valid: 1'b1, we: 1'b0, word: 1'b0, addr: a,
			wdata: 8'h00};
	endfunction : rd_byte

	function automatic csm_mem_req_s wr_byte(input logic [15:0] a,
		input logic [7:0] b);
		wr_byte = '{valid: 1'b1, we: 1'b1, word: 1'b0, addr: a,
			wdata: b};
	endfunction : wr_byte

	// apb decode
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign hit      = (paddr == `CSM_OFF_CTRL)
		|| (paddr == `CSM_OFF_STATUS)
		|| (paddr == `CSM_OFF_PC)
		|| ((paddr >= `CSM_OFF_GR0)
		&& (paddr < `CSM_OFF_PC) && (paddr[1:0] == 2'b00));
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !hit;
	assign start    = wr_acc && (paddr == `CSM_OFF_CTRL)
		&& pwdata[`CSM_CTRL_START] && !busy_reg;
	assign ack      = mreq_reg.valid && mem_ack;

	assign mem_req  = mreq_reg;
	assign busy     = busy_reg;
	assign done     = done_reg;

	// position within the moved region; walk downward when the
	// destination lies above the source so no byte is overwritten
	// before it has been read
	assign k = desc_reg ? (n_reg - `CSM_ONE - cnt_reg) : cnt_reg;
	assign src_a = s_addr_reg + so_reg + k;
	assign dst_a = d_addr_reg + do_reg + k;
	assign n_calc = min16(s_len_reg, d_len_reg);
	assign fill_cnt = d_len_reg - n_reg;
	// fill region after the copy: lsb end or msb end
	assign fill_a = (op_reg == CSM_OP_RIGHT)
		? (d_addr_reg + cnt_reg)
		: (d_addr_reg + n_reg + cnt_reg);

	// apb read data
	// 16-bit registers sit on word offsets, upper bits read zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			if (paddr == `CSM_OFF_CTRL) begin
				prdata <= {28'h0000000, inl_reg, 1'b0, op_reg};
			end else if (paddr == `CSM_OFF_STATUS) begin
				prdata <= {24'h000000, flags_reg, 2'b00, done_reg,
					busy_reg};
			end else if (paddr == `CSM_OFF_PC) begin
				prdata <= {16'h0000, pc_reg};
			end else if (hit) begin
				prdata <= {16'h0000, gr_reg[paddr[4:2] - 3'h2]};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// general registers and instruction pointer image
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int r = 0; r < `CSM_NUM_GR; r++) begin
				gr_reg[r] <= 16'h0000;
			end
			pc_reg <= 16'h0000;
		end else if (state_reg == ST_FIN && !inl_reg) begin
			gr_reg[0] <= (s_len_reg > d_len_reg)
				? (s_len_reg - d_len_reg) : 16'h0000;
			gr_reg[1] <= 16'h0000;
			gr_reg[2] <= 16'h0000;
			gr_reg[3] <= 16'h0000;
		end else if (state_reg == ST_OPF && ack) begin
			pc_reg <= pc_reg + `CSM_WORD_STEP;
		end else if (wr_acc && !busy_reg) begin
			if (paddr == `CSM_OFF_PC) begin
				pc_reg <= pwdata[15:0];
			end else if (hit && paddr != `CSM_OFF_CTRL
				&& paddr != `CSM_OFF_STATUS) begin
				gr_reg[paddr[4:2] - 3'h2] <= pwdata[15:0];
			end
		end
	end

	// control and status
	// start is dropped while busy so operands stay stable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			op_reg   <= CSM_OP_LEFT;
			inl_reg  <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start) begin
				op_reg   <= csm_op_e'(pwdata[1:0]);
				inl_reg  <= pwdata[`CSM_CTRL_INL];
				busy_reg <= 1'b1;
			end else if (state_reg == ST_FIN) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
		end
	end

	// condition codes from the initial lengths
	// borrow convention: c set when the source is shorter
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_reg <= 4'h0;
		end else if (state_reg == ST_CALC) begin
			flags_reg <= cmp_flags(s_len_reg, d_len_reg);
		end
	end

	// sequencer and memory requests
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg  <= ST_IDLE;
			mreq_reg   <= '0;
			s_len_reg  <= 16'h0000;
			s_addr_reg <= 16'h0000;
			d_len_reg  <= 16'h0000;
			d_addr_reg <= 16'h0000;
			fill_reg   <= 8'h00;
			tbl_reg    <= 16'h0000;
			ptr_s_reg  <= 16'h0000;
			ptr_d_reg  <= 16'h0000;
			idx_reg    <= 2'h0;
			n_reg      <= 16'h0000;
			so_reg     <= 16'h0000;
			do_reg     <= 16'h0000;
			desc_reg   <= 1'b0;
			cnt_reg    <= 16'h0000;
			byte_reg   <= 8'h00;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (start && pwdata[`CSM_CTRL_INL]) begin
					idx_reg   <= 2'h0;
					mreq_reg  <= rd_word(pc_reg);
					state_reg <= ST_OPF;
				end else if (start) begin
					s_len_reg  <= gr_reg[0];
					s_addr_reg <= gr_reg[1];
					d_len_reg  <= gr_reg[2];
					d_addr_reg <= gr_reg[3];
					fill_reg   <= gr_reg[4][7:0];
					tbl_reg    <= gr_reg[5];
					state_reg  <= ST_CALC;
				end
			end
			// operand words: src ptr, dst ptr, fill, then table
			ST_OPF: begin
				if (ack) begin
					case (idx_reg)
					2'h0: ptr_s_reg <= mem_rdata;
					2'h1: ptr_d_reg <= mem_rdata;
					2'h2: fill_reg  <= mem_rdata[7:0];
					default: tbl_reg <= mem_rdata;
					endcase
					if (idx_reg == ((op_reg == CSM_OP_TRANS)
						? `CSM_TBL_LAST : `CSM_FILL_LAST)) begin
						idx_reg   <= 2'h0;
						mreq_reg  <= rd_word(ptr_s_reg);
						state_reg <= ST_DSC;
					end else begin
						idx_reg  <= idx_reg + 2'h1;
						mreq_reg <= rd_word(pc_reg + `CSM_WORD_STEP);
					end
				end
			end
			// each descriptor: length word then address word
			ST_DSC: begin
				if (ack) begin
					idx_reg <= idx_reg + 2'h1;
					case (idx_reg)
					2'h0: begin
						s_len_reg <= mem_rdata;
						mreq_reg  <= rd_word(ptr_s_reg + `CSM_WORD_STEP);
					end
					2'h1: begin
						s_addr_reg <= mem_rdata;
						mreq_reg   <= rd_word(ptr_d_reg);
					end
					2'h2: begin
						d_len_reg <= mem_rdata;
						mreq_reg  <= rd_word(ptr_d_reg + `CSM_WORD_STEP);
					end
					default: begin
						d_addr_reg <= mem_rdata;
						mreq_reg   <= '0;
						state_reg  <= ST_CALC;
					end
					endcase
				end
			end
			// count, offsets and walk direction fixed once per move
			ST_CALC: begin
				n_reg   <= n_calc;
				cnt_reg <= 16'h0000;
				if (op_reg == CSM_OP_RIGHT) begin
					so_reg <= s_len_reg - n_calc;
					do_reg <= d_len_reg - n_calc;
					desc_reg <= (d_addr_reg + d_len_reg)
						> (s_addr_reg + s_len_reg);
				end else begin
					so_reg   <= 16'h0000;
					do_reg   <= 16'h0000;
					desc_reg <= d_addr_reg > s_addr_reg;
				end
				state_reg <= ST_CPY;
			end
			// one source read and one destination write per char
			ST_CPY: begin
				if (cnt_reg == n_reg) begin
					cnt_reg   <= 16'h0000;
					state_reg <= ST_FIL;
				end else begin
					mreq_reg  <= rd_byte(src_a);
					state_reg <= ST_SRD;
				end
			end
			// translated move looks the byte up before writing it
			ST_SRD: begin
				if (ack && op_reg == CSM_OP_TRANS) begin
					mreq_reg  <= rd_byte(tbl_reg
						+ {8'h00, mem_rdata[7:0]});
					state_reg <= ST_TRD;
				end else if (ack) begin
					byte_reg  <= mem_rdata[7:0];
					mreq_reg  <= wr_byte(dst_a, mem_rdata[7:0]);
					state_reg <= ST_DWR;
				end
			end
			ST_TRD: begin
				if (ack) begin
					byte_reg  <= mem_rdata[7:0];
					mreq_reg  <= wr_byte(dst_a, mem_rdata[7:0]);
					state_reg <= ST_DWR;
				end
			end
			ST_DWR: begin
				if (ack) begin
					mreq_reg  <= '0;
					cnt_reg   <= cnt_reg + `CSM_ONE;
					state_reg <= ST_CPY;
				end
			end
			// fill writes start only after every source read
			ST_FIL: begin
				if (cnt_reg == fill_cnt) begin
					mreq_reg  <= '0;
					state_reg <= ST_FIN;
				end else begin
					mreq_reg  <= wr_byte(fill_a, fill_reg);
					state_reg <= ST_FWR;
				end
			end
			ST_FWR: begin
				if (ack) begin
					mreq_reg  <= '0;
					cnt_reg   <= cnt_reg + `CSM_ONE;
					state_reg <= ST_FIL;
				end
			end
			// inline form never writes the general registers
			ST_FIN: begin
				state_reg <= ST_IDLE;
			end
			default: begin
				mreq_reg  <= '0;
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

endmodule : csm_unit

// ---- test/csm_unit_monitor.sv ----
`timescale 1ns/1ns
module csm_unit_monitor
	import csm_pkg::*;
(
	// clock and reset
	input wire logic         core_clk,
	input wire logic         sys_rst,
	// apb
	input wire logic         psel,
	input wire logic         penable,
	input wire logic [7:0]   paddr,
	input wire logic         pslverr,
	// memory and status
	input wire csm_mem_req_s mem_req,
	input wire logic         mem_ack,
	input wire logic         busy,
	input wire logic         done
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	property p_hold;
		mem_req.valid && !mem_ack |=> $stable(mem_req);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_busy;
		mem_req.valid |-> busy;
	endproperty
	a_busy: assert property (p_busy) else $error("request idle");
	property p_wbyte;
		mem_req.valid && mem_req.we |-> !mem_req.word;
	endproperty
	a_wbyte: assert property (p_wbyte) else $error("word write");
	property p_pulse;
		done |=> !done;
	endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_end;
		done |-> !busy && !mem_req.valid;
	endproperty
	a_end: assert property (p_end) else $error("done while active");
	property p_fell;
		$fell(busy) && !$past(sys_rst) |-> done;
	endproperty
	a_fell: assert property (p_fell) else $error("busy fell alone");
	property p_rose;
		$rose(done) |-> $past(busy);
	endproperty
	a_rose: assert property (p_rose) else $error("done from idle");
	property p_err;
		psel && penable && paddr > 8'h20 |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped accepted");

	c_done: cover property (done);
	c_fill: cover property (mem_req.valid && mem_req.we && mem_req.wdata == 8'h2a);
	c_err: cover property (psel && penable && pslverr);
endmodule : csm_unit_monitor

bind csm_unit csm_unit_monitor u_mon (
	.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pslverr(pslverr),
	.mem_req(mem_req), .mem_ack(mem_ack), .busy(busy), .done(done)
);

// ---- test/csm_mem_model.sv ----
`timescale 1ns/1ns
module csm_mem_model
	import csm_pkg::*;
(
	// clock and request
	input wire logic         core_clk,
	input wire csm_mem_req_s mem_req,
	input wire logic [1:0]   slow,
	// answer
	output logic             mem_ack,
	output logic [15:0]      mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_cnt;

	initial begin
		mem_ack = 1'h0;
		mem_rdata = 16'h0;
		wait_cnt = 2'h0;
	end
	// read data churns when not answering
	always @(posedge core_clk) begin
		mem_ack <= 1'h0;
		mem_rdata <= ~mem_rdata;
		if (mem_req.valid && !mem_ack) begin
			if (wait_cnt < slow) begin
				wait_cnt <= wait_cnt + 2'h1;
			end else begin
				wait_cnt <= 2'h0;
				mem_ack <= 1'h1;
				if (mem_req.we) begin
					mem[mem_req.addr] <= mem_req.wdata;
				end else begin
					mem_rdata <= {mem[mem_req.addr + 16'h1], mem[mem_req.addr]};
				end
			end
		end
	end
endmodule : csm_mem_model

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench import csm_pkg::*;;
	typedef struct {
		logic [1:0]  op;
		logic        inl;
		logic [15:0] sl;
		logic [15:0] dl;
		logic [1:0]  sw;
	} csm_row_s;
	logic         core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic         mem_ack, busy, done, perr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [15:0]  mem_rdata;
	logic [1:0]   slow;
	csm_mem_req_s mem_req;
	int           error_cnt, comparisons;
	csm_row_s     rows [13] = '{
		'{2'h0, 1'h0, 16'h3, 16'h5, 2'h0}, '{2'h0, 1'h0, 16'h5, 16'h3, 2'h1},
		'{2'h0, 1'h0, 16'h4, 16'h4, 2'h0}, '{2'h1, 1'h0, 16'h3, 16'h5, 2'h2},
		'{2'h1, 1'h0, 16'h5, 16'h2, 2'h0}, '{2'h2, 1'h0, 16'h3, 16'h5, 2'h0},
		'{2'h2, 1'h0, 16'h5, 16'h3, 2'h1}, '{2'h0, 1'h1, 16'h2, 16'h4, 2'h0},
		'{2'h1, 1'h1, 16'h5, 16'h2, 2'h1}, '{2'h2, 1'h1, 16'h3, 16'h3, 2'h0},
		'{2'h2, 1'h1, 16'h0, 16'h3, 2'h0}, '{2'h1, 1'h0, 16'h3, 16'h0, 2'h0},
		'{2'h0, 1'h0, 16'h8000, 16'h1, 2'h0}
	};

	csm_unit DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.busy(busy), .done(done));
	csm_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req),
		.slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task results;
		$display("compares %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			results;
		end
		rd = prdata;
		perr = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic run(input logic [1:0] op, input logic inl,
		input logic [15:0] sl, dl, sa, da, input logic [1:0] sw);
		logic [15:0] w [8];
		logic [15:0] r;
		logic [7:0]  e;
		int          j, n;
		w = '{16'h308, 16'h30c, 16'h2a, 16'h400, sl, sa, dl, da};
		r = sl - dl;
		slow <= sw;
		for (int i = 0; i <= dl; i++) u_mem.mem[da + i] = 8'hee;
		for (int i = 0; i < sl && i < 8; i++) u_mem.mem[sa + i] = 8'h41 + i;
		for (int i = 0; i < 8; i++)
			{u_mem.mem[16'h301 + 2 * i], u_mem.mem[16'h300 + 2 * i]} = w[i];
		for (int k = 0; k < 6; k++)
			apb(1'h1, 8'(8 + 4 * k), w[k < 4 ? k + 4 : k - 2]);
		apb(1'h1, 8'h20, 32'h300);
		apb(1'h1, 8'h00, {23'h0, 1'h1, 4'h0, inl, 1'h0, op});
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (done !== 1'h1 && n < 5000);
		if (n >= 5000) begin
			error_cnt++;
			results;
		end
		apb(1'h0, 8'h04, 32'h0);
		chk(rd[1:0], 2'h0);
		chk(rd[7:4], {r[15], r == 0, sl[15] != dl[15] && dl[15] == r[15], sl < dl});
		for (int k = 0; k < 4; k++) begin
			apb(1'h0, 8'(8 + 4 * k), 32'h0);
			chk(rd, inl ? w[k + 4] : (k == 0 && sl > dl ? r : 16'h0));
		end
		apb(1'h0, 8'h20, 32'h0);
		chk(rd, inl ? (op == 2'h2 ? 32'h308 : 32'h306) : 32'h300);
		for (int i = 0; i <= dl; i++) begin
			j = op == 2'h1 ? i + sl - dl : i;
			e = j < 0 || j >= sl ? 8'h2a : 8'h41 + j[7:0] ^ (op == 2'h2 ? 8'h5a : 8'h0);
			if (i == dl) e = 8'hee;
			chk(u_mem.mem[da + i], e);
		end
		$display("test end: op %0d inline %0d len %h/%h", op, inl, sl, dl);
	endtask : run

	initial begin
		sys_rst = 1'h1;
		{psel, penable, pwrite, paddr, pwdata, slow} = '0;
		error_cnt = 0;
		comparisons = 0;
		for (int i = 0; i < 256; i++) u_mem.mem[16'h400 + i] = i[7:0] ^ 8'h5a;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'h0;
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, 8'h40, 32'h1);
		chk(perr, 1'h1);
		apb(1'h0, 8'h40, 32'h0);
		chk({perr, rd}, {1'h1, 32'h0});
		$display("test end: reset and unmapped");
		foreach (rows[k])
			run(rows[k].op, rows[k].inl, rows[k].sl, rows[k].dl, 16'h100, 16'h200, rows[k].sw);
		run(2'h0, 1'h0, 16'h4, 16'h4, 16'h100, 16'h102, 2'h0);
		run(2'h1, 1'h0, 16'h4, 16'h4, 16'h100, 16'h102, 2'h1);
		results;
	end
endmodule : testbench
